// >>> gcss_top.sv
// global clock network source selection with two modelled plls and a register port
// What this block does
// - enable low drops lock, zeroes pll outputs
// - reset high zeroes lock and pll outputs
// - phase detector off keeps outputs toggling, lock held at its last value
// - lock asserts 2 to 10 input cycles
// - input frequency change rechecks vco range, drops lock
// - eight nets from dedicated, dual-purpose or pll
// - internal fabric signals also selectable as sources
// - every net reaches whole fabric as clock/control
// - dedicated inputs feed pll reference or nets
// - dedicated inputs map 0:0,2 1:1,3 2:4,6 3:5,7
// - dual-purpose pins 0-7 map to 3,2,0,4,6,7,5,1
// - pll outputs map to fixed network pairs
//
// The address-and-strobe port and the placing of the registers were decided locally.
`default_nettype none
`include "gcss_regs.svh"
module gcss_top #(
  parameter int NETS = 8
) (
  input  wire logic        clk_sys,
  input  wire logic        reset_n,
  input  wire logic [7:0]  reg_addr,
  input  wire logic [31:0] reg_wdata,
  input  wire logic        reg_wr,
  input  wire logic        reg_rd,
  output var  logic [31:0] reg_rdata,
  input  wire logic [3:0]  dedicated_clock_in,
  input  wire logic [7:0]  dual_purpose_clock_pin,
  input  wire logic [7:0]  internal_src,
  output var  logic [7:0]  global_clock_net,
  output var  logic [1:0]  pll_locked,
  output var  logic        irq
);
  import gcss_pkg::*;

  logic [3:0]                 ded_s1_reg, ded_s2_reg;
  logic [7:0]                 dp_s1_reg, dp_s2_reg;
  logic [23:0]                sel_reg, sel_next;
  gcss_pll_ctrl_t             pll1_ctrl_reg, pll1_ctrl_next;
  gcss_pll_ctrl_t             pll2_ctrl_reg, pll2_ctrl_next;
  logic [`GCSS_IRQ_BITS-1:0]  irq_stat_reg, irq_stat_next;
  logic [`GCSS_IRQ_BITS-1:0]  irq_mask_reg, irq_mask_next;
  logic [`GCSS_IRQ_BITS-1:0]  events;
  logic [31:0]                rdata_next;
  logic [7:0]                 net_next;
  logic                       irq_next;
  logic                       sel_reject;
  gcss_pll_stat_t             pll1_stat, pll2_stat;
  logic [3:0]                 pll_outs;

  // dedicated input that reaches a net
  function automatic logic [1:0] ded_for_net(input int n);
    case (n)
      0, 2:    return 2'h0;
      1, 3:    return 2'h1;
      4, 6:    return 2'h2;
      default: return 2'h3;
    endcase
  endfunction : ded_for_net

  // dual-purpose pin that reaches a net
  function automatic logic [2:0] dp_for_net(input int n);
    case (n)
      0:       return 3'h2;
      1:       return 3'h7;
      2:       return 3'h1;
      3:       return 3'h0;
      4:       return 3'h3;
      5:       return 3'h6;
      6:       return 3'h4;
      default: return 3'h5;
    endcase
  endfunction : dp_for_net

  // pll output index {pll2 b, pll2 a, pll1 b, pll1 a} that reaches a net
  function automatic logic [1:0] pll_for_net(input int n);
    case (n)
      1, 2:    return 2'h0;
      0, 3:    return 2'h1;
      5, 6:    return 2'h2;
      default: return 2'h3;
    endcase
  endfunction : pll_for_net

  // a selection word is legal only if every field names a permitted source
  function automatic logic sel_legal(input logic [23:0] w);
    logic ok;
    ok = 1'b1;
    for (int n = 0; n < NETS; n++)
    begin
      if (w[n*`GCSS_SEL_FIELD_W +: `GCSS_SEL_FIELD_W] >= `GCSS_SEL_SOURCES)
      begin
        ok = 1'b0;
      end
    end
    return ok;
  endfunction : sel_legal

  function automatic gcss_pll_ctrl_t ctrl_from(input logic [31:0] c, input logic [31:0] s);
    gcss_pll_ctrl_t r;
    r.enable  = c[`GCSS_CTRL_ENABLE_BIT];
    r.areset  = c[`GCSS_CTRL_ARESET_BIT];
    r.pfd_en  = c[`GCSS_CTRL_PFD_BIT];
    r.ref_sel = c[`GCSS_CTRL_REFSEL_BIT];
    r.mult    = c[`GCSS_CTRL_MULT_LSB +: 8];
    r.div     = c[`GCSS_CTRL_DIV_LSB +: 8];
    r.half_a  = s[`GCSS_SCALE_A_LSB +: 8];
    r.half_b  = s[`GCSS_SCALE_B_LSB +: 8];
    return r;
  endfunction : ctrl_from

  function automatic logic [31:0] ctrl_word(input gcss_pll_ctrl_t r);
    return {8'h00, r.div, r.mult, 4'h0, r.ref_sel, r.pfd_en, r.areset, r.enable};
  endfunction : ctrl_word

  // pin inputs come from outside the clock domain
  always_ff @(posedge clk_sys)
  begin
    if (!reset_n)
    begin
      ded_s1_reg <= 4'h0;
      ded_s2_reg <= 4'h0;
      dp_s1_reg  <= 8'h00;
      dp_s2_reg  <= 8'h00;
    end
    else
    begin
      ded_s1_reg <= dedicated_clock_in;
      ded_s2_reg <= ded_s1_reg;
      dp_s1_reg  <= dual_purpose_clock_pin;
      dp_s2_reg  <= dp_s1_reg;
    end
  end

  // pll1 reference from input 0 or 1, pll2 from input 2 or 3
  gcss_pll_model u_pll1 (
    .clk_sys (clk_sys),
    .reset_n (reset_n),
    .ref_in  (pll1_ctrl_reg.ref_sel ? ded_s2_reg[1] : ded_s2_reg[0]),
    .ctrl    (pll1_ctrl_reg),
    .stat    (pll1_stat)
  );

  gcss_pll_model u_pll2 (
    .clk_sys (clk_sys),
    .reset_n (reset_n),
    .ref_in  (pll2_ctrl_reg.ref_sel ? ded_s2_reg[3] : ded_s2_reg[2]),
    .ctrl    (pll2_ctrl_reg),
    .stat    (pll2_stat)
  );

  // register port, event capture and status
  always_comb
  begin
    pll_outs       = {pll2_stat.post_scale_out_b, pll2_stat.post_scale_out_a,
                      pll1_stat.post_scale_out_b, pll1_stat.post_scale_out_a};
    sel_next       = sel_reg;
    pll1_ctrl_next = pll1_ctrl_reg;
    pll2_ctrl_next = pll2_ctrl_reg;
    irq_mask_next  = irq_mask_reg;
    sel_reject     = 1'b0;
    rdata_next     = 32'h00000000;
    if (reg_wr)
    begin
      case (reg_addr)
        `GCSS_OFS_NET_SEL:
        begin
          // a bad word leaves every net on its old source
          if (sel_legal(reg_wdata[23:0]))
          begin
            sel_next = reg_wdata[23:0];
          end
          else
          begin
            sel_reject = 1'b1;
          end
        end
        `GCSS_OFS_PLL1_CTRL:  pll1_ctrl_next = ctrl_from(reg_wdata, {16'h0000, pll1_ctrl_reg.half_b, pll1_ctrl_reg.half_a});
        `GCSS_OFS_PLL2_CTRL:  pll2_ctrl_next = ctrl_from(reg_wdata, {16'h0000, pll2_ctrl_reg.half_b, pll2_ctrl_reg.half_a});
        `GCSS_OFS_PLL1_SCALE: pll1_ctrl_next = ctrl_from(ctrl_word(pll1_ctrl_reg), reg_wdata);
        `GCSS_OFS_PLL2_SCALE: pll2_ctrl_next = ctrl_from(ctrl_word(pll2_ctrl_reg), reg_wdata);
        `GCSS_OFS_IRQ_MASK:   irq_mask_next  = reg_wdata[`GCSS_IRQ_BITS-1:0];
        default:              sel_next       = sel_reg;
      endcase
    end
    if (reg_rd)
    begin
      case (reg_addr)
        `GCSS_OFS_NET_SEL:    rdata_next = {8'h00, sel_reg};
        `GCSS_OFS_PLL1_CTRL:  rdata_next = ctrl_word(pll1_ctrl_reg);
        `GCSS_OFS_PLL2_CTRL:  rdata_next = ctrl_word(pll2_ctrl_reg);
        `GCSS_OFS_PLL1_SCALE: rdata_next = {16'h0000, pll1_ctrl_reg.half_b, pll1_ctrl_reg.half_a};
        `GCSS_OFS_PLL2_SCALE: rdata_next = {16'h0000, pll2_ctrl_reg.half_b, pll2_ctrl_reg.half_a};
        `GCSS_OFS_STATE:      rdata_next = {28'h0000000, pll2_stat.in_range, pll1_stat.in_range,
                                            pll2_stat.locked, pll1_stat.locked};
        `GCSS_OFS_IRQ_STATUS: rdata_next = {25'h0000000, irq_stat_reg};
        `GCSS_OFS_IRQ_MASK:   rdata_next = {25'h0000000, irq_mask_reg};
        default:              rdata_next = 32'h00000000;
      endcase
    end
    events = '0;
    events[`GCSS_IRQ_LOCK1_RISE] = pll1_stat.lock_rise;
    events[`GCSS_IRQ_LOCK1_FALL] = pll1_stat.lock_fall;
    events[`GCSS_IRQ_LOCK2_RISE] = pll2_stat.lock_rise;
    events[`GCSS_IRQ_LOCK2_FALL] = pll2_stat.lock_fall;
    events[`GCSS_IRQ_SEL_REJECT] = sel_reject;
    events[`GCSS_IRQ_RANGE1]     = pll1_stat.range_fault;
    events[`GCSS_IRQ_RANGE2]     = pll2_stat.range_fault;
    // a new event beats a write-one-to-clear in the same cycle
    irq_stat_next = irq_stat_reg;
    if (reg_wr && (reg_addr == `GCSS_OFS_IRQ_STATUS))
    begin
      irq_stat_next = irq_stat_reg & ~reg_wdata[`GCSS_IRQ_BITS-1:0];
    end
    irq_stat_next = irq_stat_next | events;
    irq_next      = |(irq_stat_next & irq_mask_next);
  end

  // one source per net; nets are registered, so each adds a cycle of latency
  always_comb
  begin
    for (int n = 0; n < NETS; n++)
    begin
      case (gcss_src_t'(sel_reg[n*`GCSS_SEL_FIELD_W +: `GCSS_SEL_FIELD_W]))
        GCSS_SRC_DEDICATED: net_next[n] = ded_s2_reg[ded_for_net(n)];
        GCSS_SRC_DUAL_PIN:  net_next[n] = dp_s2_reg[dp_for_net(n)];
        GCSS_SRC_PLL:       net_next[n] = pll_outs[pll_for_net(n)];
        GCSS_SRC_INTERNAL:  net_next[n] = internal_src[n];
        default:            net_next[n] = 1'b0;
      endcase
    end
  end

  always_ff @(posedge clk_sys)
  begin
    if (!reset_n)
    begin
      sel_reg          <= `GCSS_RST_NET_SEL;
      pll1_ctrl_reg    <= ctrl_from(`GCSS_RST_PLL_CTRL, `GCSS_RST_PLL_SCALE);
      pll2_ctrl_reg    <= ctrl_from(`GCSS_RST_PLL_CTRL, `GCSS_RST_PLL_SCALE);
      irq_stat_reg     <= '0;
      irq_mask_reg     <= `GCSS_RST_IRQ_MASK;
      reg_rdata        <= 32'h00000000;
      global_clock_net <= 8'h00;
      pll_locked       <= 2'h0;
      irq              <= 1'b0;
    end
    else
    begin
      sel_reg          <= sel_next;
      pll1_ctrl_reg    <= pll1_ctrl_next;
      pll2_ctrl_reg    <= pll2_ctrl_next;
      irq_stat_reg     <= irq_stat_next;
      irq_mask_reg     <= irq_mask_next;
      reg_rdata        <= rdata_next;
      global_clock_net <= net_next;
      pll_locked       <= {pll2_stat.locked, pll1_stat.locked};
      irq              <= irq_next;
    end
  end

endmodule : gcss_top
`default_nettype wire

// >>> gcss_regs.svh
// register offsets, field positions, reset values and timing counts of the clock source selector
`ifndef GCSS_REGS_SVH
`define GCSS_REGS_SVH

`define GCSS_OFS_NET_SEL      8'h00
`define GCSS_OFS_PLL1_CTRL    8'h04
`define GCSS_OFS_PLL2_CTRL    8'h08
`define GCSS_OFS_PLL1_SCALE   8'h0c
`define GCSS_OFS_PLL2_SCALE   8'h10
`define GCSS_OFS_STATE        8'h14
`define GCSS_OFS_IRQ_STATUS   8'h18
`define GCSS_OFS_IRQ_MASK     8'h1c

`define GCSS_SEL_FIELD_W      3
`define GCSS_SEL_SOURCES      3'h4

`define GCSS_CTRL_ENABLE_BIT  0
`define GCSS_CTRL_ARESET_BIT  1
`define GCSS_CTRL_PFD_BIT     2
`define GCSS_CTRL_REFSEL_BIT  3
`define GCSS_CTRL_MULT_LSB    8
`define GCSS_CTRL_DIV_LSB     16
`define GCSS_SCALE_A_LSB      0
`define GCSS_SCALE_B_LSB      8

`define GCSS_RST_NET_SEL      24'h000000
`define GCSS_RST_PLL_CTRL     32'h00010102
`define GCSS_RST_PLL_SCALE    32'h00000202
`define GCSS_RST_IRQ_MASK     7'h00

`define GCSS_IRQ_LOCK1_RISE   0
`define GCSS_IRQ_LOCK1_FALL   1
`define GCSS_IRQ_LOCK2_RISE   2
`define GCSS_IRQ_LOCK2_FALL   3
`define GCSS_IRQ_SEL_REJECT   4
`define GCSS_IRQ_RANGE1       5
`define GCSS_IRQ_RANGE2       6
`define GCSS_IRQ_BITS         7

`define GCSS_LOCK_EDGES       4
`define GCSS_VCO_PER_MIN      16'h0001
`define GCSS_VCO_PER_MAX      16'h0040

`endif

// >>> gcss_pkg.sv
// types shared by the clock source selector and its pll control model
`default_nettype none
package gcss_pkg;

  typedef enum logic [2:0] {
    GCSS_SRC_DEDICATED,
    GCSS_SRC_DUAL_PIN,
    GCSS_SRC_PLL,
    GCSS_SRC_INTERNAL
  } gcss_src_t;

  typedef struct packed {
    logic       enable;
    logic       areset;
    logic       pfd_en;
    logic       ref_sel;
    logic [7:0] mult;
    logic [7:0] div;
    logic [7:0] half_a;
    logic [7:0] half_b;
  } gcss_pll_ctrl_t;

  typedef struct packed {
    logic locked;
    logic in_range;
    logic lock_rise;
    logic lock_fall;
    logic range_fault;
    logic post_scale_out_a;
    logic post_scale_out_b;
  } gcss_pll_stat_t;

endpackage : gcss_pkg
`default_nettype wire

// >>> gcss_pll_model.sv
// digital model of one pll: enable, reset, phase detector, lock and vco range check
`default_nettype none
`include "gcss_regs.svh"
module gcss_pll_model #(
  parameter int             LOCK_EDGES  = `GCSS_LOCK_EDGES,
  parameter logic [15:0]    VCO_PER_MIN = `GCSS_VCO_PER_MIN,
  parameter logic [15:0]    VCO_PER_MAX = `GCSS_VCO_PER_MAX
) (
  input  wire logic                     clk_sys,
  input  wire logic                     reset_n,
  input  wire logic                     ref_in,
  input  wire gcss_pkg::gcss_pll_ctrl_t ctrl,
  output var  gcss_pkg::gcss_pll_stat_t stat
);
  import gcss_pkg::*;

  typedef enum logic [1:0] {PL_OFF, PL_MEASURE, PL_TRACK} gcss_pl_state_t;

  gcss_pl_state_t state_reg, state_next;
  logic           ref_prev_reg, ref_prev_next;
  logic [15:0]    per_cnt_reg, per_cnt_next;
  logic [15:0]    meas_reg, meas_next;
  logic           have_meas_reg, have_meas_next;
  logic [3:0]     edge_cnt_reg, edge_cnt_next;
  logic [7:0]     act_half_a_reg, act_half_a_next;
  logic [7:0]     act_half_b_reg, act_half_b_next;
  logic [7:0]     cnt_a_reg, cnt_a_next;
  logic [7:0]     cnt_b_reg, cnt_b_next;
  gcss_pll_stat_t stat_next;
  logic           ref_rise;
  logic           run;

  // vco period = input period * div / mult, kept inside the limits without a divider
  function automatic logic range_ok(input logic [15:0] per, input logic [7:0] m, input logic [7:0] d);
    logic [31:0] lhs;
    lhs = 32'(per) * 32'(d);
    return (m != 8'h00) && (d != 8'h00) &&
           (lhs >= 32'(VCO_PER_MIN) * 32'(m)) && (lhs <= 32'(VCO_PER_MAX) * 32'(m));
  endfunction : range_ok

  always_comb
  begin
    run             = ctrl.enable && !ctrl.areset;
    ref_rise        = ref_in && !ref_prev_reg;
    ref_prev_next   = ref_in;
    state_next      = state_reg;
    per_cnt_next    = per_cnt_reg;
    meas_next       = meas_reg;
    have_meas_next  = have_meas_reg;
    edge_cnt_next   = edge_cnt_reg;
    act_half_a_next = act_half_a_reg;
    act_half_b_next = act_half_b_reg;
    cnt_a_next      = cnt_a_reg;
    cnt_b_next      = cnt_b_reg;
    stat_next       = stat;
    stat_next.lock_rise   = 1'b0;
    stat_next.lock_fall   = 1'b0;
    stat_next.range_fault = 1'b0;
    if (!run)
    begin
      // disabled or held in reset: lock and both post-scale outputs forced low
      state_next            = PL_OFF;
      per_cnt_next          = 16'h0000;
      have_meas_next        = 1'b0;
      edge_cnt_next         = 4'h0;
      cnt_a_next            = 8'h00;
      cnt_b_next            = 8'h00;
      stat_next.locked      = 1'b0;
      stat_next.in_range    = 1'b0;
      stat_next.post_scale_out_a = 1'b0;
      stat_next.post_scale_out_b = 1'b0;
      stat_next.lock_fall   = stat.locked;
    end
    else
    begin
      if (per_cnt_reg != 16'hffff)
      begin
        per_cnt_next = per_cnt_reg + 16'h0001;
      end
      // phase detector off: frequency and lock state are frozen, outputs keep running
      if (ctrl.pfd_en)
      begin
        act_half_a_next = (ctrl.half_a == 8'h00) ? 8'h01 : ctrl.half_a;
        act_half_b_next = (ctrl.half_b == 8'h00) ? 8'h01 : ctrl.half_b;
        case (state_reg)
          PL_OFF:
          begin
            state_next = PL_MEASURE;
          end
          PL_MEASURE, PL_TRACK:
          begin
            if (ref_rise)
            begin
              per_cnt_next   = 16'h0001;
              meas_next      = per_cnt_reg;
              have_meas_next = 1'b1;
              if (have_meas_reg && (per_cnt_reg != meas_reg))
              begin
                // input frequency moved: restart tracking and recheck the range
                state_next       = PL_MEASURE;
                edge_cnt_next    = 4'h0;
                stat_next.locked = 1'b0;
                stat_next.lock_fall = stat.locked;
              end
              else if (have_meas_reg && !range_ok(per_cnt_reg, ctrl.mult, ctrl.div))
              begin
                state_next            = PL_MEASURE;
                edge_cnt_next         = 4'h0;
                stat_next.in_range    = 1'b0;
                stat_next.range_fault = stat.in_range || (state_reg == PL_TRACK);
                stat_next.locked      = 1'b0;
                stat_next.lock_fall   = stat.locked;
              end
              else if (have_meas_reg)
              begin
                state_next         = PL_TRACK;
                stat_next.in_range = 1'b1;
                if (edge_cnt_reg < 4'(LOCK_EDGES))
                begin
                  edge_cnt_next = edge_cnt_reg + 4'h1;
                end
                if ((edge_cnt_reg + 4'h1 == 4'(LOCK_EDGES)) && !stat.locked)
                begin
                  stat_next.locked    = 1'b1;
                  stat_next.lock_rise = 1'b1;
                end
              end
            end
          end
          default:
          begin
            state_next = PL_OFF;
          end
        endcase
      end
      // post-scale dividers toggle at the active half period
      if (cnt_a_reg + 8'h01 >= act_half_a_reg)
      begin
        cnt_a_next                 = 8'h00;
        stat_next.post_scale_out_a = !stat.post_scale_out_a;
      end
      else
      begin
        cnt_a_next = cnt_a_reg + 8'h01;
      end
      if (cnt_b_reg + 8'h01 >= act_half_b_reg)
      begin
        cnt_b_next                 = 8'h00;
        stat_next.post_scale_out_b = !stat.post_scale_out_b;
      end
      else
      begin
        cnt_b_next = cnt_b_reg + 8'h01;
      end
    end
  end

  always_ff @(posedge clk_sys)
  begin
    if (!reset_n)
    begin
      state_reg      <= PL_OFF;
      ref_prev_reg   <= 1'b0;
      per_cnt_reg    <= 16'h0000;
      meas_reg       <= 16'h0000;
      have_meas_reg  <= 1'b0;
      edge_cnt_reg   <= 4'h0;
      act_half_a_reg <= 8'h01;
      act_half_b_reg <= 8'h01;
      cnt_a_reg      <= 8'h00;
      cnt_b_reg      <= 8'h00;
      stat           <= '0;
    end
    else
    begin
      state_reg      <= state_next;
      ref_prev_reg   <= ref_prev_next;
      per_cnt_reg    <= per_cnt_next;
      meas_reg       <= meas_next;
      have_meas_reg  <= have_meas_next;
      edge_cnt_reg   <= edge_cnt_next;
      act_half_a_reg <= act_half_a_next;
      act_half_b_reg <= act_half_b_next;
      cnt_a_reg      <= cnt_a_next;
      cnt_b_reg      <= cnt_b_next;
      stat           <= stat_next;
    end
  end

endmodule : gcss_pll_model
`default_nettype wire

// >>> gcss_props.sv
// port assertions for the global clock source selector
`default_nettype none
module gcss_props (
  input wire logic        clk_sys,
  input wire logic        reset_n,
  input wire logic [7:0]  reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic        reg_wr,
  input wire logic        reg_rd,
  input wire logic [31:0] reg_rdata,
  input wire logic [7:0]  internal_src,
  input wire logic [7:0]  global_clock_net,
  input wire logic [1:0]  pll_locked,
  input wire logic        irq
);
  logic [23:0] sel_reg;
  logic [23:0] sel_next;
  logic [1:0]  run_reg;
  logic [1:0]  run_next;
  timeunit 1ns;
  timeprecision 100ps;
  default clocking @(posedge clk_sys); endclocking
  default disable iff (!reset_n);
  // shadow of the accepted selection; words with a field of 4 or more never land
  always_comb
  begin
    sel_next = sel_reg;
    run_next = run_reg;
    if (reg_wr && reg_addr == 8'h00 && (reg_wdata[23:0] & 24'h924924) == 24'h0)
      sel_next = reg_wdata[23:0];
    if (reg_wr && reg_addr == 8'h04)
      run_next[0] = reg_wdata[0] & ~reg_wdata[1];
    if (reg_wr && reg_addr == 8'h08)
      run_next[1] = reg_wdata[0] & ~reg_wdata[1];
  end
  always_ff @(posedge clk_sys)
  begin
    sel_reg <= reset_n ? sel_next : 24'h0;
    run_reg <= reset_n ? run_next : 2'h0;
  end
  for (genvar n = 0; n < 8; n++)
  begin : route_g
    int_route_a:
      assert property ((sel_reg[3*n+:3] == 3'h3) |=> (global_clock_net[n] == $past(internal_src[n])))
      else $error("net does not follow its internal source");
  end
  ded_pair_a:
    assert property ((sel_reg == 24'h0) |-> (global_clock_net[5:4] == global_clock_net[7:6]
      && global_clock_net[1:0] == global_clock_net[3:2])) else $error("dedicated net pair differs");
  pll_pair_a:
    // nets lag the selection by one flop, so the word must have stood a cycle already
    assert property ((sel_reg == 24'h492492 && $past(sel_reg) == 24'h492492) |-> (global_clock_net[1] == global_clock_net[2]
      && global_clock_net[0] == global_clock_net[3] && global_clock_net[5] == global_clock_net[6]
      && global_clock_net[4] == global_clock_net[7])) else $error("pll net pair differs");
  lock1_off_a: assert property ((!run_reg[0]) [*5] |-> !pll_locked[0])
    else $error("pll1 locked while stopped");
  lock2_off_a: assert property ((!run_reg[1]) [*5] |-> !pll_locked[1])
    else $error("pll2 locked while stopped");
  pll_zero_a: assert property ((!run_reg[0] && sel_reg[5:3] == 3'h2) [*6] |-> !global_clock_net[1])
    else $error("stopped pll output not low");
  lock_rise_a: assert property ($rose(pll_locked[0]) |-> run_reg[0] && $past(run_reg[0], 2))
    else $error("lock rose without a running loop");
  rdata_idle_a: assert property ((!reg_rd) |=> (reg_rdata == 32'h0))
    else $error("read data not zero outside reply");
  irq_off_a: assert property ((reg_wr && reg_addr == 8'h1c && reg_wdata[6:0] == 7'h0) |=> ##1 !irq)
    else $error("irq high with all masked");
endmodule : gcss_props
bind gcss_top gcss_props chk_u (.clk_sys(clk_sys), .reset_n(reset_n), .reg_addr(reg_addr),
  .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
  .internal_src(internal_src), .global_clock_net(global_clock_net), .pll_locked(pll_locked), .irq(irq));
`default_nettype wire

// >>> gcss_fabric_model.sv
// fabric side: drives internal candidates and counts rising edges on one global net
`default_nettype none
module gcss_fabric_model (
  input  wire logic        clk_sys,
  input  wire logic        spin,
  input  wire logic        clr,
  input  wire logic [7:0]  pat,
  input  wire logic [2:0]  watch,
  input  wire logic [7:0]  global_clock_net,
  output var  logic [7:0]  internal_src,
  output var  logic [15:0] edges
);
  timeunit 1ns;
  timeprecision 100ps;
  logic last;
  // while spin is high the pattern rotates one place each cycle across the internal candidates
  always @(posedge clk_sys)
  begin
    internal_src <= spin ? {internal_src[6:0], internal_src[7]} : pat;
    last         <= global_clock_net[watch];
    if (clr)
      edges <= 16'h0;
    else if (global_clock_net[watch] && !last)
      edges <= edges + 16'h1;
  end
endmodule : gcss_fabric_model
`default_nettype wire

// >>> gcss_top_tb.sv
// self-checking bench for the global clock source selector
`default_nettype none
module gcss_top_tb;
  timeunit 1ns;
  timeprecision 100ps;
  logic        clk_sys = 1'b0, reset_n = 1'b0, reg_wr = 1'b0, reg_rd = 1'b0, spin = 1'b0, clr = 1'b0;
  logic [7:0]  reg_addr = 8'h00, dual_purpose_clock_pin = 8'h00, pat = 8'h00, internal_src, global_clock_net;
  logic [31:0] reg_wdata = 32'h0, reg_rdata, q;
  logic [3:0]  dedicated_clock_in = 4'h0;
  logic [2:0]  watch = 3'h0;
  logic [1:0]  pll_locked;
  logic [15:0] edges;
  logic        irq;
  int          ref_half = 0, rcnt = 0, ref_rise = 0, error_cnt = 0, n_compared = 0, n;
  gcss_top dut_u (.clk_sys(clk_sys), .reset_n(reset_n), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .dedicated_clock_in(dedicated_clock_in),
    .dual_purpose_clock_pin(dual_purpose_clock_pin), .internal_src(internal_src),
    .global_clock_net(global_clock_net), .pll_locked(pll_locked), .irq(irq));
  gcss_fabric_model fab_u (.clk_sys(clk_sys), .spin(spin), .clr(clr), .pat(pat), .watch(watch),
    .global_clock_net(global_clock_net), .internal_src(internal_src), .edges(edges));
  initial
  begin
    forever #2.5 clk_sys = ~clk_sys;
  end
  // board reference on dedicated input 0 while ref_half is nonzero
  always @(posedge clk_sys)
  begin
    if (ref_half != 0)
    begin
      if (rcnt >= ref_half - 1)
      begin
        rcnt <= 0;
        dedicated_clock_in[0] <= ~dedicated_clock_in[0];
        ref_rise <= ref_rise + (dedicated_clock_in[0] ? 0 : 1);
      end
      else
        rcnt <= rcnt + 1;
    end
  end
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_compared++;
    if (got !== exp)
    begin
      error_cnt++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk_sys);
    reg_addr  <= a;
    reg_wdata <= d;
    reg_wr    <= 1'b1;
    @(posedge clk_sys);
    reg_wr    <= 1'b0;
  endtask : wr
  task automatic rdc(input logic [7:0] a, input logic [31:0] m, input logic [31:0] exp);
    @(posedge clk_sys);
    reg_addr <= a;
    reg_rd   <= 1'b1;
    @(posedge clk_sys);
    reg_rd   <= 1'b0;
    #1 chk(reg_rdata & m, exp);
  endtask : rdc
  task automatic idle(input int c);
    repeat (c) @(posedge clk_sys);
    #1;
  endtask : idle
  task automatic edges_in(input logic [2:0] w, input int lo, input int hi);
    @(posedge clk_sys);
    watch <= w;
    clr   <= 1'b1;
    @(posedge clk_sys);
    clr   <= 1'b0;
    idle(64);
    chk({31'h0, edges >= lo && edges <= hi}, 32'h1);
  endtask : edges_in
  // counts board reference rises from the control write until lock shows
  task automatic run_lock(input logic [31:0] ctrl);
    int s;
    s = ref_rise;
    wr(8'h04, ctrl);
    for (int i = 0; i < 400 && pll_locked[0] !== 1'b1; i++)
      idle(1);
    n = ref_rise - s;
  endtask : run_lock
  task automatic reset_vals();
    logic [7:0]  ra [8] = '{8'h00, 8'h04, 8'h08, 8'h0c, 8'h10, 8'h18, 8'h1c, 8'h24};
    logic [31:0] rv [8] = '{32'h0, 32'h00010102, 32'h00010102, 32'h202, 32'h202, 32'h0, 32'h0, 32'h0};
    for (int i = 0; i < 8; i++)
      rdc(ra[i], 32'hffffffff, rv[i]);
  endtask : reset_vals
  task automatic routing();
    logic [7:0] de [4] = '{8'h05, 8'h0a, 8'h50, 8'ha0};
    int         dm [8] = '{3, 2, 0, 4, 6, 7, 5, 1};
    for (int i = 0; i < 4; i++)
    begin
      @(posedge clk_sys);
      dedicated_clock_in <= 4'h1 << i;
      idle(5);
      chk({24'h0, global_clock_net}, {24'h0, de[i]});
    end
    wr(8'h00, 32'h00249249);
    for (int i = 0; i < 8; i++)
    begin
      @(posedge clk_sys);
      dual_purpose_clock_pin <= 8'h01 << i;
      idle(5);
      chk({24'h0, global_clock_net}, 32'h1 << dm[i]);
    end
    wr(8'h00, 32'h006db6db);
    @(posedge clk_sys);
    pat <= 8'h5a;
    idle(3);
    chk({24'h0, global_clock_net}, 32'h5a);
    @(posedge clk_sys);
    spin <= 1'b1;
    idle(20);
  endtask : routing
  task automatic pll_ctrl();
    wr(8'h00, 32'h00492492);
    wr(8'h1c, 32'h7f);
    wr(8'h0c, 32'h0302);
    ref_half = 4;
    run_lock(32'h00010105);
    chk({31'h0, n >= 2 && n <= 10}, 32'h1);
    chk({31'h0, irq}, 32'h1);
    rdc(8'h18, 32'h1, 32'h1);
    edges_in(3'h1, 15, 17);
    edges_in(3'h0, 10, 11);
    edges_in(3'h4, 0, 0);
    wr(8'h04, 32'h00010101);
    edges_in(3'h1, 15, 17);
    wr(8'h04, 32'h00010105);
    ref_half = 40;
    idle(300);
    chk({31'h0, pll_locked[0]}, 32'h0);
    rdc(8'h14, 32'h4, 32'h0);
    rdc(8'h18, 32'h20, 32'h20);
    ref_half = 4;
    run_lock(32'h00010105);
    chk({31'h0, pll_locked[0]}, 32'h1);
    wr(8'h04, 32'h00010104);
    idle(8);
    chk({30'h0, pll_locked}, 32'h0);
    edges_in(3'h1, 0, 0);
    run_lock(32'h00010105);
    wr(8'h04, 32'h00010107);
    idle(8);
    chk({30'h0, pll_locked}, 32'h0);
    edges_in(3'h1, 0, 0);
  endtask : pll_ctrl
  task automatic reject_irq();
    wr(8'h18, 32'h7f);
    rdc(8'h18, 32'h7f, 32'h0);
    wr(8'h1c, 32'h0);
    wr(8'h00, 32'h00fff000);
    rdc(8'h00, 32'hffffff, 32'h492492);
    chk({31'h0, irq}, 32'h0);
    rdc(8'h18, 32'h10, 32'h10);
    wr(8'h1c, 32'h10);
    idle(2);
    chk({31'h0, irq}, 32'h1);
    wr(8'h18, 32'h10);
    idle(2);
    chk({31'h0, irq}, 32'h0);
  endtask : reject_irq
  task automatic complete_run();
    if (error_cnt == 0 && n_compared > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask : complete_run
  initial
  begin
    #200000;
    error_cnt++;
    complete_run();
  end
  initial
  begin
    repeat (16) @(posedge clk_sys);
    reset_n <= 1'b1;
    reset_vals();
    routing();
    pll_ctrl();
    reject_irq();
    complete_run();
  end
endmodule : gcss_top_tb
`default_nettype wire
